//--- hw/bscan_pkg.sv
// Shared constants and types for the test-port instruction and data path.
// Assumes one system clock samples the test port pins; no bus reaches it.
package bscan_pkg;
  localparam int IR_W = 6;
  localparam int ID_W = 32;
  localparam int BUF_DEPTH = 2;
  localparam logic [IR_W-1:0] OP_EXTEST = 6'h00;
  localparam logic [IR_W-1:0] OP_SAMPLE = 6'h01;
  localparam logic [IR_W-1:0] OP_IDCODE = 6'h02;
  localparam logic [IR_W-1:0] OP_HIGHZ = 6'h03;
  localparam logic [IR_W-1:0] CAPTURE_IR_PATTERN_OPCODE = 6'h2d;
  localparam logic [IR_W-1:0] OP_CLAMP = 6'h3e;
  localparam logic [IR_W-1:0] OP_BYPASS = 6'h3f;
  // Arbitrary identification value; only bit 0 being set matters
  localparam logic [ID_W-1:0] ID_VALUE_DEFAULT = 32'h0a5a_5a5b;
  localparam logic BYPASS_CAPTURE = 1'h0;
  localparam logic [2:0] TLR_TMS_COUNT = 3'h5;
  localparam int TCK_PERIOD_NS = 320;
  localparam int CLK_PERIOD_NS = 40;
  // Clock cycles in one test-clock period
  localparam int TCK_CYCLES = TCK_PERIOD_NS / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UPD_IR
  } tap_state_e;

  typedef enum logic [1:0] {SEL_BYP, SEL_BSR, SEL_ID} dr_sel_e;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_b;
  } tap_pins_s;

  typedef struct packed {
    logic bit_val;
    logic drive;
  } tdo_word_s;

  // Reserved codes fall back to the one-bit bypass path
  function automatic dr_sel_e dr_select(logic [IR_W-1:0] op);
    if (op == OP_EXTEST || op == OP_SAMPLE) begin
      dr_select = SEL_BSR;
    end else if (op == OP_IDCODE) begin
      dr_select = SEL_ID;
    end else begin
      dr_select = SEL_BYP;
    end
  endfunction : dr_select
endpackage : bscan_pkg

//--- hw/bscan_path.sv
// Test port instruction register, data registers and boundary cells.
// Assumes all test pins and pads are asynchronous to CLK and synchronised here.
module bscan_path
  import bscan_pkg::*;
#(
  parameter int N_IN = 4,
  parameter int N_OUT = 4,
  parameter int N_BID = 4,
  parameter logic [ID_W-1:0] ID_VALUE = ID_VALUE_DEFAULT
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CE,
  input wire logic TCK,
  input wire logic TMS,
  input wire logic TDI,
  input wire logic TRST_B,
  output logic TDO,
  output logic TDO_OE_B,
  input wire logic [N_IN-1:0] IN_PAD,
  output logic [N_IN-1:0] CORE_IN,
  input wire logic [N_OUT-1:0] CORE_OUT,
  output logic [N_OUT-1:0] OUT_PAD,
  output logic [N_OUT-1:0] OUT_OE_B,
  input wire logic [N_BID-1:0] CORE_BID_O,
  input wire logic [N_BID-1:0] CORE_BID_OE,
  output logic [N_BID-1:0] CORE_BID_I,
  input wire logic [N_BID-1:0] BID_I,
  output logic [N_BID-1:0] BID_O,
  output logic [N_BID-1:0] BID_OE_B
);
  localparam int OB = N_IN;
  localparam int BB = N_IN + N_OUT;
  localparam int BSR_W = N_IN + N_OUT + 2 * N_BID;

  tap_pins_s pins_meta_ff, pins_s_ff;
  logic tck_prev_ff;
  logic [N_IN-1:0] in_meta_ff, in_s_ff;
  logic [N_BID-1:0] bid_meta_ff, bid_s_ff;
  tap_state_e state_ff;
  logic [IR_W-1:0] ir_sh_ff, ir_ff;
  logic byp_ff;
  logic [ID_W-1:0] id_sh_ff;
  logic [BSR_W-1:0] bsr_ff, cap_vec;
  logic [N_OUT-1:0] upd_out_ff;
  logic [N_BID-1:0] upd_oe_ff, upd_bd_ff;
  tdo_word_s buf_mem_ff [BUF_DEPTH];
  logic buf_wr_ff, buf_rd_ff;
  logic [1:0] buf_cnt_ff;
  logic tdo_ff, tdo_oe_b_ff;
  logic [N_IN-1:0] core_in_ff;
  logic [N_OUT-1:0] out_pad_ff, out_oe_b_ff;
  logic [N_BID-1:0] core_bid_i_ff, bid_o_ff, bid_oe_b_ff;
  logic [2:0] tms_cnt_ff;
  logic tck_rise, tck_fall, trst_act, ext_act, drive_latch, hz_act;
  logic buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready;
  tdo_word_s buf_in;
  dr_sel_e sel;

  // Two-flop synchronisers for every asynchronous input
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pins_meta_ff <= '0;
      pins_s_ff <= '0;
      tck_prev_ff <= 1'h0;
      in_meta_ff <= '0;
      in_s_ff <= '0;
      bid_meta_ff <= '0;
      bid_s_ff <= '0;
    end else if (CE) begin
      pins_meta_ff <= '{tck: TCK, tms: TMS, tdi: TDI, trst_b: TRST_B};
      pins_s_ff <= pins_meta_ff;
      tck_prev_ff <= pins_s_ff.tck;
      in_meta_ff <= IN_PAD;
      in_s_ff <= in_meta_ff;
      bid_meta_ff <= BID_I;
      bid_s_ff <= bid_meta_ff;
    end
  end

  assign tck_rise = pins_s_ff.tck & ~tck_prev_ff;
  assign tck_fall = ~pins_s_ff.tck & tck_prev_ff;
  assign trst_act = ~pins_s_ff.trst_b;
  assign sel = dr_select(ir_ff);
  assign ext_act = (ir_ff == OP_EXTEST);
  assign drive_latch = ext_act || (ir_ff == OP_CLAMP);
  assign hz_act = (ir_ff == OP_HIGHZ);

  function automatic tap_state_e tap_next(tap_state_e s, logic tms);
    unique case (s)
      ST_TLR: tap_next = tms ? ST_TLR : ST_RTI;
      ST_RTI: tap_next = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: tap_next = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: tap_next = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: tap_next = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: tap_next = tms ? ST_UPD_DR : ST_PA_DR;
      ST_PA_DR: tap_next = tms ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: tap_next = tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: tap_next = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: tap_next = tms ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: tap_next = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: tap_next = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: tap_next = tms ? ST_UPD_IR : ST_PA_IR;
      ST_PA_IR: tap_next = tms ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: tap_next = tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: tap_next = tms ? ST_SEL_DR : ST_RTI;
    endcase
  endfunction : tap_next

  // Controller state, advanced on each rising test-clock edge
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_ff <= ST_TLR;
    end else if (CE) begin
      if (trst_act) begin
        state_ff <= ST_TLR;
      end else if (tck_rise) begin
        state_ff <= tap_next(state_ff, pins_s_ff.tms);
      end
    end
  end

  // Instruction shift stage and current instruction
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ir_sh_ff <= CAPTURE_IR_PATTERN_OPCODE;
      ir_ff <= OP_IDCODE;
    end else if (CE) begin
      if (trst_act || state_ff == ST_TLR) begin
        ir_ff <= OP_IDCODE;
      end else if (tck_fall && state_ff == ST_UPD_IR) begin
        ir_ff <= ir_sh_ff;
      end
      if (tck_rise && state_ff == ST_CAP_IR) begin
        ir_sh_ff <= CAPTURE_IR_PATTERN_OPCODE;
      end else if (tck_rise && state_ff == ST_SH_IR) begin
        ir_sh_ff <= {pins_s_ff.tdi, ir_sh_ff[IR_W-1:1]};
      end
    end
  end

  // Capture sources for each boundary cell
  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++) begin : g_in_cell
      assign cap_vec[gi] = in_s_ff[gi];
    end
    for (gi = 0; gi < N_OUT; gi++) begin : g_out_cell
      assign cap_vec[OB+gi] = CORE_OUT[gi];
    end
    for (gi = 0; gi < N_BID; gi++) begin : g_bid_cell
      assign cap_vec[BB+2*gi] = CORE_BID_OE[gi];
      assign cap_vec[BB+2*gi+1] = (CORE_BID_OE[gi] && !ext_act) ? CORE_BID_O[gi] : bid_s_ff[gi];
    end
  endgenerate

  // Data registers; only the selected one captures or shifts
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      byp_ff <= BYPASS_CAPTURE;
      id_sh_ff <= '0;
      bsr_ff <= '0;
    end else if (CE && tck_rise) begin
      if (sel == SEL_BYP) begin
        if (state_ff == ST_CAP_DR) begin
          byp_ff <= BYPASS_CAPTURE;
        end else if (state_ff == ST_SH_DR) begin
          byp_ff <= pins_s_ff.tdi;
        end
      end
      if (sel == SEL_ID) begin
        if (state_ff == ST_CAP_DR) begin
          id_sh_ff <= ID_VALUE;
        end else if (state_ff == ST_SH_DR) begin
          id_sh_ff <= {pins_s_ff.tdi, id_sh_ff[ID_W-1:1]};
        end
      end
      if (sel == SEL_BSR) begin
        if (state_ff == ST_CAP_DR) begin
          bsr_ff <= cap_vec;
        end else if (state_ff == ST_SH_DR) begin
          bsr_ff <= {pins_s_ff.tdi, bsr_ff[BSR_W-1:1]};
        end
      end
    end
  end

  // Update latches load on the falling edge in Update-DR
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      upd_out_ff <= '0;
      upd_oe_ff <= '0;
      upd_bd_ff <= '0;
    end else if (CE && tck_fall && state_ff == ST_UPD_DR && sel == SEL_BSR) begin
      upd_out_ff <= bsr_ff[BB-1:OB];
      for (int k = 0; k < N_BID; k++) begin
        upd_oe_ff[k] <= bsr_ff[BB+2*k];
        upd_bd_ff[k] <= bsr_ff[BB+2*k+1];
      end
    end
  end

  // Pin and core drive; normal path untouched unless a test instruction is current
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      core_in_ff <= '0;
      core_bid_i_ff <= '0;
      out_pad_ff <= '0;
      out_oe_b_ff <= '1;
      bid_o_ff <= '0;
      bid_oe_b_ff <= '1;
    end else if (CE) begin
      core_in_ff <= in_s_ff;
      core_bid_i_ff <= bid_s_ff;
      out_pad_ff <= drive_latch ? upd_out_ff : CORE_OUT;
      bid_o_ff <= drive_latch ? upd_bd_ff : CORE_BID_O;
      if (hz_act) begin
        out_oe_b_ff <= '1;
        bid_oe_b_ff <= '1;
      end else begin
        out_oe_b_ff <= '0;
        bid_oe_b_ff <= drive_latch ? ~upd_oe_ff : ~CORE_BID_OE;
      end
    end
  end

  // Serial output bit, taken at the falling edge into a two-entry buffer
  assign buf_in.bit_val = (state_ff == ST_SH_IR) ? ir_sh_ff[0] :
                          (sel == SEL_BSR) ? bsr_ff[0] :
                          (sel == SEL_ID) ? id_sh_ff[0] : byp_ff;
  assign buf_in.drive = (state_ff == ST_SH_IR) || (state_ff == ST_SH_DR);
  assign buf_in_valid = tck_fall;
  assign buf_in_ready = (buf_cnt_ff != 2'(BUF_DEPTH));
  assign buf_out_valid = (buf_cnt_ff != 2'h0);
  assign buf_out_ready = 1'h1;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      buf_wr_ff <= 1'h0;
      buf_rd_ff <= 1'h0;
      buf_cnt_ff <= 2'h0;
      for (int k = 0; k < BUF_DEPTH; k++) begin
        buf_mem_ff[k] <= '0;
      end
    end else if (CE) begin
      if (buf_in_valid && buf_in_ready) begin
        buf_mem_ff[buf_wr_ff] <= buf_in;
        buf_wr_ff <= ~buf_wr_ff;
      end
      if (buf_out_valid && buf_out_ready) begin
        buf_rd_ff <= ~buf_rd_ff;
      end
      buf_cnt_ff <= buf_cnt_ff + 2'(buf_in_valid && buf_in_ready) - 2'(buf_out_valid && buf_out_ready);
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      tdo_ff <= 1'h0;
      tdo_oe_b_ff <= 1'h1;
    end else if (CE && trst_act) begin
      tdo_oe_b_ff <= 1'h1;
    end else if (CE && buf_out_valid && buf_out_ready) begin
      tdo_ff <= buf_mem_ff[buf_rd_ff].bit_val;
      tdo_oe_b_ff <= ~buf_mem_ff[buf_rd_ff].drive;
    end
  end

  assign TDO = tdo_ff;
  assign TDO_OE_B = tdo_oe_b_ff;
  assign CORE_IN = core_in_ff;
  assign CORE_BID_I = core_bid_i_ff;
  assign OUT_PAD = out_pad_ff;
  assign OUT_OE_B = out_oe_b_ff;
  assign BID_O = bid_o_ff;
  assign BID_OE_B = bid_oe_b_ff;

  // Count of consecutive rising edges with mode select high
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      tms_cnt_ff <= 3'h0;
    end else if (CE && tck_rise) begin
      if (!pins_s_ff.tms) begin
        tms_cnt_ff <= 3'h0;
      end else if (tms_cnt_ff != TLR_TMS_COUNT) begin
        tms_cnt_ff <= tms_cnt_ff + 3'h1;
      end
    end
  end

  a_tms_five_reset: assert property (@(posedge CLK) disable iff (!RST_B)
    tms_cnt_ff == TLR_TMS_COUNT |-> state_ff == ST_TLR)
    else $error("five mode-high edges did not reach test-logic reset");

  a_trst_idcode: assert property (@(posedge CLK) disable iff (!RST_B)
    CE && trst_act |=> state_ff == ST_TLR && ir_ff == OP_IDCODE)
    else $error("test reset did not select identification instruction");

  a_ir_capture_pat: assert property (@(posedge CLK) disable iff (!RST_B)
    CE && tck_rise && state_ff == ST_CAP_IR |=> ir_sh_ff == CAPTURE_IR_PATTERN_OPCODE)
    else $error("capture-ir pattern not loaded");

  a_ir_hold_update: assert property (@(posedge CLK) disable iff (!RST_B)
    !(tck_fall && state_ff == ST_UPD_IR) && !trst_act && state_ff != ST_TLR |=> $stable(ir_ff))
    else $error("instruction changed outside update-ir");

  a_bypass_zero: assert property (@(posedge CLK) disable iff (!RST_B)
    CE && tck_rise && state_ff == ST_CAP_DR && sel == SEL_BYP |=> byp_ff == BYPASS_CAPTURE)
    else $error("bypass register not cleared at capture-dr");

  a_id_lsb_one: assert property (@(posedge CLK) disable iff (!RST_B)
    CE && tck_rise && state_ff == ST_CAP_DR && sel == SEL_ID |=> id_sh_ff[0] && id_sh_ff == ID_VALUE)
    else $error("identification capture wrong");

  a_highz_pins: assert property (@(posedge CLK) disable iff (!RST_B)
    CE && hz_act ##1 CE && hz_act |-> &out_oe_b_ff && &bid_oe_b_ff)
    else $error("pins not tri-stated under highz");

  a_clamp_drive: assert property (@(posedge CLK) disable iff (!RST_B)
    CE && drive_latch ##1 CE && drive_latch && $stable(upd_out_ff) && $stable(upd_bd_ff) |->
    out_pad_ff == upd_out_ff && bid_o_ff == upd_bd_ff)
    else $error("pins not driven from update latches");

  a_tdo_idle_hiz: assert property (@(posedge CLK) disable iff (!RST_B)
    state_ff == ST_TLR [*3] ##1 state_ff == ST_TLR |-> tdo_oe_b_ff)
    else $error("serial output driven outside shift states");

  a_chain_select: assert property (@(posedge CLK) disable iff (!RST_B)
    CE && tck_rise && state_ff == ST_CAP_DR && (ir_ff == OP_EXTEST || ir_ff == OP_SAMPLE) |=>
    bsr_ff == $past(cap_vec))
    else $error("boundary chain not selected");
endmodule : bscan_path

//--- dv/tap_ctl_model.sv
// Behavioural board-level test controller for the test port.
// Assumes calls start on a falling CLK edge; the test clock idles low between frames.
module tap_ctl_model
  import bscan_pkg::*;
(
  input wire logic clk,
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_b,
  input wire logic tdo,
  input wire logic tdo_oe_b
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = TCK_CYCLES / 2;

  // Mode select and serial in rest at their pull-up level
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h1;
    trst_b = 1'h1;
  end

  // One test-clock period; serial out is taken just before the rise
  task automatic tick(input logic m, input logic d, output logic so, output logic drv);
    tms = m;
    tdi = d;
    repeat (HALF) @(negedge clk);
    so = tdo;
    drv = ~tdo_oe_b;
    tck = 1'h1;
    repeat (HALF) @(negedge clk);
    tck = 1'h0;
  endtask : tick

  // Scan from idle back to idle, LSB first
  task automatic scan(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout,
                      output logic drv_all);
    logic so;
    logic drv;
    dout = 64'h0;
    drv_all = 1'h1;
    tick(1'h1, 1'h1, so, drv);
    if (ir) begin
      tick(1'h1, 1'h1, so, drv);
    end
    tick(1'h0, 1'h1, so, drv);
    tick(1'h0, 1'h1, so, drv);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], so, drv);
      dout[i] = so;
      drv_all = drv_all & drv;
    end
    tick(1'h1, 1'h1, so, drv);
    tick(1'h0, 1'h1, so, drv);
  endtask : scan

  // Mode select held high for five rises, then on to idle
  task automatic to_reset();
    logic so;
    logic drv;
    repeat (TLR_TMS_COUNT) tick(1'h1, 1'h1, so, drv);
    tick(1'h0, 1'h1, so, drv);
  endtask : to_reset

  task automatic pulse_trst();
    trst_b = 1'h0;
    repeat (TCK_CYCLES) @(negedge clk);
    trst_b = 1'h1;
    repeat (HALF) @(negedge clk);
  endtask : pulse_trst
endmodule : tap_ctl_model

//--- dv/testbench.sv
// Self-checking bench for the test port path with a controller model.
// Assumes default widths of four pins per kind; two-way pads resolved here.
module testbench
  import bscan_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, ce, tck, tms, tdi, trst_b, tdo, tdo_oe_b;
  logic [3:0] in_pad, core_in, core_out, out_pad, out_oe_b, core_bid_o, core_bid_oe;
  logic [3:0] core_bid_i, bid_i, bid_o, bid_oe_b, ext_bid;
  int errors = 0;
  int tests_run = 0;

  // Two-way pad: the block wins where it drives, else the board value
  assign bid_i = (~bid_oe_b & bid_o) | (bid_oe_b & ext_bid);

  bscan_path dut (.CLK(clk), .RST_B(rst_b), .CE(ce), .TCK(tck), .TMS(tms), .TDI(tdi), .TRST_B(trst_b),
    .TDO(tdo), .TDO_OE_B(tdo_oe_b), .IN_PAD(in_pad), .CORE_IN(core_in), .CORE_OUT(core_out),
    .OUT_PAD(out_pad), .OUT_OE_B(out_oe_b), .CORE_BID_O(core_bid_o), .CORE_BID_OE(core_bid_oe),
    .CORE_BID_I(core_bid_i), .BID_I(bid_i), .BID_O(bid_o), .BID_OE_B(bid_oe_b));

  tap_ctl_model ctl (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .trst_b(trst_b), .tdo(tdo),
    .tdo_oe_b(tdo_oe_b));

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  task automatic give_verdict();
    if (errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got, input logic [63:0] m);
    tests_run++;
    if ((got & m) !== (exp & m)) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp & m, got & m);
    end
  endtask : chk

  task automatic sc(input logic is_ir, input int n, input logic [63:0] din, output logic [63:0] dout);
    logic drv;
    ctl.scan(is_ir, n, din, dout, drv);
    chk("serial out drive", 64'h1, 64'(drv), 64'h1);
    chk("serial out idle", 64'h1, 64'(tdo_oe_b), 64'h1);
  endtask : sc

  task automatic ir(input logic [5:0] op);
    logic [63:0] d;
    sc(1'h1, IR_W, 64'(op), d);
    chk("ir capture", 64'h2d, d, 64'h3f);
  endtask : ir

  // Expected boundary capture; ext selects external-test pad sourcing
  function automatic logic [15:0] cap_exp(input logic ext, input logic [15:0] lat);
    logic [15:0] v;
    v[3:0] = in_pad;
    v[7:4] = core_out;
    for (int k = 0; k < 4; k++) begin
      v[8 + 2 * k] = core_bid_oe[k];
      if (!ext && core_bid_oe[k]) v[9 + 2 * k] = core_bid_o[k];
      else if (ext && lat[8 + 2 * k]) v[9 + 2 * k] = lat[9 + 2 * k];
      else v[9 + 2 * k] = ext_bid[k];
    end
    return v;
  endfunction : cap_exp

  // Mode 0 normal, 1 all tri-stated, 2 driven from the update latches
  task automatic chk_pads(input int mode, input logic [15:0] lat);
    logic [3:0] en;
    logic [3:0] dv;
    for (int k = 0; k < 4; k++) begin
      en[k] = mode == 2 ? lat[8 + 2 * k] : (mode == 0 && core_bid_oe[k]);
      dv[k] = mode == 2 ? lat[9 + 2 * k] : core_bid_o[k];
    end
    chk("core in", 64'(in_pad), 64'(core_in), 64'hf);
    chk("core bid in", 64'((en & dv) | (~en & ext_bid)), 64'(core_bid_i), 64'hf);
    chk("bid oe", 64'(~en), 64'(bid_oe_b), 64'hf);
    chk("bid out", 64'(dv), 64'(bid_o), 64'(en));
    chk("out oe", mode == 1 ? 64'hf : 64'h0, 64'(out_oe_b), 64'hf);
    chk("out pad", 64'(mode == 2 ? lat[7:4] : core_out), 64'(out_pad), mode == 1 ? 64'h0 : 64'hf);
  endtask : chk_pads

  task automatic s_idcode();
    logic [63:0] d;
    sc(1'h0, ID_W, 64'h0, d);
    chk("id value", 64'(ID_VALUE_DEFAULT), d, 64'hffff_ffff);
  endtask : s_idcode

  task automatic s_opcodes();
    logic [5:0] ops [9] = '{OP_SAMPLE, OP_IDCODE, OP_HIGHZ, 6'h04, 6'h2c, 6'h2d, 6'h2e, 6'h3d, OP_BYPASS};
    logic [63:0] din = 64'h00a5_3c96;
    logic [63:0] d;
    foreach (ops[i]) begin
      ir(ops[i]);
      chk_pads(ops[i] == OP_HIGHZ ? 1 : 0, 16'h0);
      sc(1'h0, 24, din, d);
      if (ops[i] == OP_SAMPLE) begin
        chk("sample capture", {40'h0, din[7:0], cap_exp(1'h0, 16'h0)}, d, 64'hff_ffff);
      end else if (ops[i] == OP_IDCODE) begin
        chk("id path", 64'(ID_VALUE_DEFAULT), d, 64'hff_ffff);
      end else begin
        chk("bypass path", {din[62:0], 1'h0}, d, 64'hff_ffff);
      end
    end
  endtask : s_opcodes

  task automatic s_extest();
    logic [15:0] p = 16'h59c3;
    logic [15:0] q = 16'ha61e;
    logic [63:0] d;
    ir(OP_SAMPLE);
    sc(1'h0, 16, 64'(p), d);
    ir(OP_EXTEST);
    chk_pads(2, p);
    ext_bid = 4'h9;
    sc(1'h0, 16, 64'(q), d);
    chk("extest capture", 64'(cap_exp(1'h1, p)), d, 64'haa0f);
    chk_pads(2, q);
    ir(OP_CLAMP);
    chk_pads(2, q);
    sc(1'h0, 8, 64'h5a, d);
    chk("clamp bypass", 64'hb4, d, 64'hff);
    ir(OP_EXTEST);
    ctl.to_reset();
    chk_pads(0, 16'h0);
    sc(1'h0, 1, 64'h0, d);
    chk("id first bit", 64'h1, d, 64'h1);
    ir(OP_EXTEST);
    ctl.pulse_trst();
    chk_pads(0, 16'h0);
    ctl.to_reset();
    s_idcode();
  endtask : s_extest

  initial begin
    clk = 1'h0;
    rst_b = 1'h0;
    ce = 1'h1;
    in_pad = 4'ha;
    core_out = 4'h6;
    core_bid_o = 4'h5;
    core_bid_oe = 4'h3;
    ext_bid = 4'hc;
    repeat (4) @(negedge clk);
    chk("reset serial enable", 64'h1, 64'(tdo_oe_b), 64'h1);
    rst_b = 1'h1;
    repeat (4) @(negedge clk);
    ctl.to_reset();
    s_idcode();
    s_opcodes();
    s_extest();
    give_verdict();
  end

  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    give_verdict();
  end
endmodule : testbench
